// file: core/lcr_pkg.sv
// shared constants and types for the link control register block
package lcr_pkg;
  // register map, byte addresses on the register bus
  localparam logic [7:0] LINK_CONTROL_ADDR = 8'h08;
  localparam logic [31:0] LINK_CONTROL_RESET = 32'h0000_0000;
  localparam int CTRL_WIDTH = 9;
  // field positions inside link_control
  localparam int NODE_IDENTITY_VALID_BIT = 0;
  localparam int SELF_ID_CAPTURE_BIT = 1;
  localparam int FORCED_BUSY_BIT = 2;
  localparam int ACCEPT_ALL_ISO_BIT = 3;
  localparam int CYCLE_START_CAPTURE_BIT = 4;
  localparam int ASYNC_TX_EN_BIT = 5;
  localparam int ASYNC_RX_EN_BIT = 6;
  localparam int ISO_TX_EN_BIT = 7;
  localparam int ISO_RX_EN_BIT = 8;
  // node address that every node accepts
  localparam logic [5:0] BROADCAST_NODE_ID = 6'h3f;
  // status codes attached to a stored self-id packet
  localparam logic [3:0] SELF_ID_GOOD = 4'h1;
  localparam logic [3:0] SELF_ID_BAD = 4'hd;
  localparam logic [3:0] STATUS_NONE = 4'h0;
  // kinds of received packet reported by the receiver
  typedef enum logic [2:0]
  {
    KIND_ASYNC = 3'h0,
    KIND_ISO = 3'h1,
    KIND_CYCLE_START = 3'h2,
    KIND_SELF_ID = 3'h3,
    KIND_LINK_ON = 3'h4,
    KIND_PHY_CONFIG = 3'h5
  } lcr_kind_type;
endpackage

// file: core/lcr_link_control.sv
// link control register low nine bits with packet acceptance and transmit gating
//
// How it works
// - link_control sits at offset 08h, read/write, all bits zero after reset.
// - node id valid set accepts own-address packets; clear accepts broadcast only.
// - stored self-id status is 1h when data good, Dh when wrong.
// - self-id capture also stores link-on and phy config, first quadlet only.
// - forced busy answers every accepted non-broadcast async packet with ack_busy_x.
// - forced busy clear sends ack_busy_x only when the receive fifo is full.
// - accept-all-iso plus iso receive stores every iso packet, any channel.
// - cycle-start capture writes each received cycle-start packet to the fifo.
// - async transmit enable clear blocks arbitration and async sends.
// - bus reset clears async transmit enable, node number may have changed.
// - async receive enable clear accepts no async packets at all.
// - bus reset clears async receive enable.
// - iso transmit enable clear blocks arbitration for iso packets.
// - iso receive enable clear accepts no iso packets.
// - destination node 3Fh is accepted whatever the local node id while async receive is enabled.
`timescale 1ns/1ns
module lcr_link_control
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // classic wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // node identity and bus events from the link core
  input wire logic [5:0] LOCAL_NODE_ID,
  input wire logic BUS_RESET,
  // received packet header from the receiver
  input wire logic RX_VALID,
  input wire logic [2:0] RX_KIND,
  input wire logic [5:0] RX_DEST,
  input wire logic RX_CHANNEL_MATCH,
  input wire logic [31:0] RX_QUAD0,
  input wire logic [31:0] RX_QUAD1,
  input wire logic GENERAL_RECEIVE_FIFO_FULL,
  // receive decision
  output logic RX_STORE,
  output logic RX_ACK_BUSY,
  output logic RX_FIRST_QUAD_ONLY,
  output logic RX_SELF_ID_MERGE,
  output logic [3:0] RX_STATUS,
  // transmit gating
  input wire logic TX_ASYNC_REQ,
  input wire logic TX_ISO_REQ,
  output logic TX_ASYNC_ARB,
  output logic TX_ISO_ARB,
  // control bits as levels for the link core
  output logic [8:0] LINK_CONTROL
);

  typedef struct packed
  {
    logic [8:0] ctrl;
    logic ack;
    logic [31:0] rdat;
    logic store;
    logic busy;
    logic first_only;
    logic sid_merge;
    logic [3:0] status;
  } lcr_state_type;

  lcr_state_type state;
  lcr_state_type next_state;

  // destination decode used by both async acceptance and busy policy
  function automatic logic is_broadcast(input logic [5:0] dest);
    is_broadcast = (dest == lcr_pkg::BROADCAST_NODE_ID);
  endfunction

  logic bus_req;
  logic wr_ctrl;
  logic rd_sel;
  logic [8:0] wr_val;
  logic async_accept;
  logic async_busy;
  logic iso_accept;
  logic [8:0] ctrl;

  assign ctrl = state.ctrl;
  assign bus_req = CYC_I && STB_I && !state.ack;

  // address decode; unmapped offsets answer with zero and drop writes
  always_comb
  begin
    wr_ctrl = 1'b0;
    rd_sel = 1'b0;
    if (ADR_I == lcr_pkg::LINK_CONTROL_ADDR)
    begin
      wr_ctrl = bus_req && WE_I;
      rd_sel = 1'b1;
    end
    else
    begin
      wr_ctrl = 1'b0;
      rd_sel = 1'b0;
    end
  end

  // byte-lane merge; only lanes 0 and 1 hold implemented bits
  always_comb
  begin
    wr_val = ctrl;
    if (SEL_I[0])
    begin
      wr_val[7:0] = DAT_I[7:0];
    end
    if (SEL_I[1])
    begin
      wr_val[lcr_pkg::ISO_RX_EN_BIT] = DAT_I[lcr_pkg::ISO_RX_EN_BIT];
    end
  end

  // async acceptance: enable gates all, broadcast always passes
  always_comb
  begin
    async_accept = ctrl[lcr_pkg::ASYNC_RX_EN_BIT]
      && (is_broadcast(RX_DEST)
      || (ctrl[lcr_pkg::NODE_IDENTITY_VALID_BIT] && RX_DEST == LOCAL_NODE_ID));
    // busy only answers a packet we would have taken, never a broadcast
    async_busy = async_accept && !is_broadcast(RX_DEST)
      && (ctrl[lcr_pkg::FORCED_BUSY_BIT]
      || GENERAL_RECEIVE_FIFO_FULL);
    iso_accept = ctrl[lcr_pkg::ISO_RX_EN_BIT]
      && (ctrl[lcr_pkg::ACCEPT_ALL_ISO_BIT] || RX_CHANNEL_MATCH);
  end

  // next-state logic for registers, bus answer and receive decision
  always_comb
  begin
    next_state = state;
    next_state.ack = bus_req;
    next_state.store = 1'b0;
    next_state.busy = 1'b0;
    next_state.first_only = 1'b0;
    next_state.sid_merge = 1'b0;
    next_state.status = lcr_pkg::STATUS_NONE;
    if (bus_req)
    begin
      next_state.rdat = rd_sel ? {23'h0, ctrl} : 32'h0000_0000;
    end
    if (wr_ctrl)
    begin
      next_state.ctrl = wr_val;
    end
    // bus reset beats a same-cycle software write: old node number is stale
    if (BUS_RESET)
    begin
      next_state.ctrl[lcr_pkg::ASYNC_TX_EN_BIT] = 1'b0;
      next_state.ctrl[lcr_pkg::ASYNC_RX_EN_BIT] = 1'b0;
    end
    if (RX_VALID)
    begin
      case (RX_KIND)
        lcr_pkg::KIND_ASYNC:
        begin
          next_state.busy = async_busy;
          next_state.store = async_accept && !async_busy;
        end
        lcr_pkg::KIND_ISO:
        begin
          next_state.store = iso_accept;
        end
        lcr_pkg::KIND_CYCLE_START:
        begin
          next_state.store = ctrl[lcr_pkg::CYCLE_START_CAPTURE_BIT];
        end
        lcr_pkg::KIND_SELF_ID:
        begin
          if (ctrl[lcr_pkg::SELF_ID_CAPTURE_BIT])
          begin
            next_state.store = 1'b1;
            next_state.sid_merge = 1'b1;
            next_state.status = (RX_QUAD1 == ~RX_QUAD0) ? lcr_pkg::SELF_ID_GOOD
              : lcr_pkg::SELF_ID_BAD;
          end
        end
        lcr_pkg::KIND_LINK_ON, lcr_pkg::KIND_PHY_CONFIG:
        begin
          next_state.store = ctrl[lcr_pkg::SELF_ID_CAPTURE_BIT];
          next_state.first_only = ctrl[lcr_pkg::SELF_ID_CAPTURE_BIT];
        end
        default:
        begin
          next_state.store = 1'b0;
        end
      endcase
    end
  end

  // single state register
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // outputs; arbitration requests are handshakes and stay combinational
  assign DAT_O = state.rdat;
  assign ACK_O = state.ack;
  assign RX_STORE = state.store;
  assign RX_ACK_BUSY = state.busy;
  assign RX_FIRST_QUAD_ONLY = state.first_only;
  assign RX_SELF_ID_MERGE = state.sid_merge;
  assign RX_STATUS = state.status;
  assign LINK_CONTROL = ctrl;
  assign TX_ASYNC_ARB = TX_ASYNC_REQ && ctrl[lcr_pkg::ASYNC_TX_EN_BIT];
  assign TX_ISO_ARB = TX_ISO_REQ && ctrl[lcr_pkg::ISO_TX_EN_BIT];

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);

  // a write to link_control with lanes 0 and 1 shows up in ctrl the next cycle
  ctrl_write_a: assert property (
    (wr_ctrl && !BUS_RESET && SEL_I[1:0] == 2'b11) |=> (ctrl == $past(DAT_I[8:0])))
    else $error("link_control write not stored");

  // bus reset drops both async enables next cycle
  busreset_clear_a: assert property (
    BUS_RESET |=> !ctrl[lcr_pkg::ASYNC_TX_EN_BIT] && !ctrl[lcr_pkg::ASYNC_RX_EN_BIT])
    else $error("async enables survived bus reset");

  // no async packet stored or busied while receive is off
  async_off_a: assert property (
    (RX_VALID && RX_KIND == lcr_pkg::KIND_ASYNC && !ctrl[lcr_pkg::ASYNC_RX_EN_BIT])
    |=> !RX_STORE && !RX_ACK_BUSY)
    else $error("async packet taken while receive disabled");

  // broadcast async packet stored even when node id invalid
  broadcast_take_a: assert property (
    (RX_VALID && RX_KIND == lcr_pkg::KIND_ASYNC && RX_DEST == lcr_pkg::BROADCAST_NODE_ID
      && ctrl[lcr_pkg::ASYNC_RX_EN_BIT]) |=> RX_STORE && !RX_ACK_BUSY)
    else $error("broadcast packet not stored");

  // own address rejected while node id invalid
  id_invalid_a: assert property (
    (RX_VALID && RX_KIND == lcr_pkg::KIND_ASYNC && !ctrl[lcr_pkg::NODE_IDENTITY_VALID_BIT]
      && RX_DEST != lcr_pkg::BROADCAST_NODE_ID) |=> !RX_STORE)
    else $error("addressed packet taken without valid id");

  // forced busy answers accepted directed async packets with busy
  forced_busy_a: assert property (
    (RX_VALID && RX_KIND == lcr_pkg::KIND_ASYNC && ctrl[lcr_pkg::FORCED_BUSY_BIT]
      && ctrl[lcr_pkg::ASYNC_RX_EN_BIT] && ctrl[lcr_pkg::NODE_IDENTITY_VALID_BIT]
      && RX_DEST == LOCAL_NODE_ID && RX_DEST != lcr_pkg::BROADCAST_NODE_ID)
    |=> RX_ACK_BUSY && !RX_STORE)
    else $error("forced busy not sent");

  // without forced busy a busy answer needs a full fifo
  busy_full_a: assert property (
    (RX_VALID && !ctrl[lcr_pkg::FORCED_BUSY_BIT] && !GENERAL_RECEIVE_FIFO_FULL)
    |=> !RX_ACK_BUSY)
    else $error("busy sent with fifo not full");

  // iso stored for any channel with accept-all and receive on
  iso_all_a: assert property (
    (RX_VALID && RX_KIND == lcr_pkg::KIND_ISO && ctrl[lcr_pkg::ISO_RX_EN_BIT]
      && ctrl[lcr_pkg::ACCEPT_ALL_ISO_BIT]) |=> RX_STORE)
    else $error("iso packet dropped with accept-all");

  // iso dropped while iso receive off
  iso_off_a: assert property (
    (RX_VALID && RX_KIND == lcr_pkg::KIND_ISO && !ctrl[lcr_pkg::ISO_RX_EN_BIT]) |=> !RX_STORE)
    else $error("iso packet taken while disabled");

  // cycle start stored exactly when capture is on
  cycle_start_a: assert property (
    (RX_VALID && RX_KIND == lcr_pkg::KIND_CYCLE_START)
    |=> RX_STORE == $past(ctrl[lcr_pkg::CYCLE_START_CAPTURE_BIT]))
    else $error("cycle start capture mismatch");

  // self-id status good exactly for inverted second quadlet
  self_id_code_a: assert property (
    (RX_VALID && RX_KIND == lcr_pkg::KIND_SELF_ID && ctrl[lcr_pkg::SELF_ID_CAPTURE_BIT])
    |=> RX_SELF_ID_MERGE && RX_STORE && RX_STATUS == (($past(RX_QUAD1) == ~$past(RX_QUAD0))
      ? lcr_pkg::SELF_ID_GOOD : lcr_pkg::SELF_ID_BAD))
    else $error("self-id status code wrong");

  // link-on and phy config keep only their first quadlet
  first_quad_a: assert property (
    (RX_VALID && (RX_KIND == lcr_pkg::KIND_LINK_ON || RX_KIND == lcr_pkg::KIND_PHY_CONFIG)
      && ctrl[lcr_pkg::SELF_ID_CAPTURE_BIT]) |=> RX_STORE && RX_FIRST_QUAD_ONLY)
    else $error("link-on or phy config not stored");

  // arbitration requests blocked by their enables
  tx_gate_a: assert property (
    !ctrl[lcr_pkg::ASYNC_TX_EN_BIT] |-> !TX_ASYNC_ARB)
    else $error("async arbitration while disabled");

  iso_tx_gate_a: assert property (
    !ctrl[lcr_pkg::ISO_TX_EN_BIT] |-> !TX_ISO_ARB)
    else $error("iso arbitration while disabled");

  // addressed packet with room in the fifo is stored without busy
  own_address_a: assert property (
    (RX_VALID && RX_KIND == lcr_pkg::KIND_ASYNC && ctrl[lcr_pkg::NODE_IDENTITY_VALID_BIT]
      && ctrl[lcr_pkg::ASYNC_RX_EN_BIT] && !ctrl[lcr_pkg::FORCED_BUSY_BIT]
      && !GENERAL_RECEIVE_FIFO_FULL && RX_DEST == LOCAL_NODE_ID)
    |=> RX_STORE && !RX_ACK_BUSY)
    else $error("addressed packet not stored");

  // a full fifo busies an accepted directed packet
  fifo_full_busy_a: assert property (
    (RX_VALID && RX_KIND == lcr_pkg::KIND_ASYNC && ctrl[lcr_pkg::NODE_IDENTITY_VALID_BIT]
      && ctrl[lcr_pkg::ASYNC_RX_EN_BIT] && GENERAL_RECEIVE_FIFO_FULL
      && RX_DEST == LOCAL_NODE_ID && RX_DEST != lcr_pkg::BROADCAST_NODE_ID)
    |=> RX_ACK_BUSY && !RX_STORE)
    else $error("full fifo did not busy the packet");

  // iso on a foreign channel dropped unless accept-all is set
  iso_channel_a: assert property (
    (RX_VALID && RX_KIND == lcr_pkg::KIND_ISO && !ctrl[lcr_pkg::ACCEPT_ALL_ISO_BIT]
      && !RX_CHANNEL_MATCH) |=> !RX_STORE)
    else $error("iso packet taken on foreign channel");

  // capture off keeps self-id, link-on and phy config out of the fifo
  capture_off_a: assert property (
    (RX_VALID && !ctrl[lcr_pkg::SELF_ID_CAPTURE_BIT] && (RX_KIND == lcr_pkg::KIND_SELF_ID
      || RX_KIND == lcr_pkg::KIND_LINK_ON || RX_KIND == lcr_pkg::KIND_PHY_CONFIG))
    |=> !RX_STORE && !RX_SELF_ID_MERGE && !RX_FIRST_QUAD_ONLY)
    else $error("capture-only packet taken while capture off");

  // store, busy, merge and status are one-cycle pulses that need a header
  rx_idle_a: assert property (
    !RX_VALID |=> !RX_STORE && !RX_ACK_BUSY && !RX_SELF_ID_MERGE
      && RX_STATUS == lcr_pkg::STATUS_NONE)
    else $error("receive decision without a header");

  // unmapped offsets read back zero
  unmapped_read_a: assert property (
    (CYC_I && STB_I && !ACK_O && ADR_I != lcr_pkg::LINK_CONTROL_ADDR)
    |=> DAT_O == 32'h0000_0000)
    else $error("unmapped offset read not zero");

  // enabled async transmit requests reach arbitration in the same cycle
  tx_open_a: assert property (
    (TX_ASYNC_REQ && ctrl[lcr_pkg::ASYNC_TX_EN_BIT]) |-> TX_ASYNC_ARB)
    else $error("enabled async request not passed");

  // bus answers one cycle after request then drops
  bus_ack_a: assert property (
    (CYC_I && STB_I && !ACK_O) |=> ACK_O ##1 !ACK_O)
    else $error("wishbone ack timing wrong");

endmodule

// file: tb/lcr_rx_model.sv
// receiver model that presents one packet header for each request of the bench
`timescale 1ns/1ns
module lcr_rx_model
(
  // clock and command from the bench
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [5:0] dest,
  input wire logic chan,
  input wire logic good,
  // header toward the block
  output logic rx_valid,
  output logic [2:0] rx_kind,
  output logic [5:0] rx_dest,
  output logic rx_chan,
  output logic [31:0] rx_quad0,
  output logic [31:0] rx_quad1
);
  logic [31:0] churn;
  // fields keep changing outside the valid cycle, though the two quadlets there always form an inverted pair
  initial churn = 32'h0;
  always @(posedge clk)
  begin
    churn <= churn + 32'h9e37_79b9;
  end
  // a self-id pair counts as good only when the second quadlet inverts the first
  always_comb
  begin
    rx_valid = go;
    rx_kind = go ? kind : churn[2:0];
    rx_dest = go ? dest : churn[13:8];
    rx_chan = go ? chan : churn[16];
    rx_quad0 = go ? 32'h1234_5678 : churn;
    rx_quad1 = go ? (good ? ~32'h1234_5678 : 32'h1234_5678) : ~churn;
  end
endmodule

// file: tb/testbench.sv
// self-checking bench for the link control register
`timescale 1ns/1ns
module testbench;
  logic sys_clk, reset_n, cyc, stb, we, ack, bus_reset, fifo_full, tx_a, tx_i, arb_a, arb_i;
  logic store, busy, firstq, merge, go, chan, good, rx_valid, rx_chan;
  logic [7:0] adr;
  logic [3:0] sel, status, lanes;
  logic [31:0] dat_w, dat_r, rd, q0, q1;
  logic [8:0] ctrl;
  logic [5:0] node_id, dest, rx_dest;
  logic [2:0] kind, rx_kind;
  int errors = 0;
  int n_compared = 0;
  // block under test and the receiver in front of it
  lcr_link_control lcr_link_control_inst (.SYS_CLK(sys_clk), .RESET_N(reset_n), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r),
    .ACK_O(ack), .LOCAL_NODE_ID(node_id), .BUS_RESET(bus_reset), .RX_VALID(rx_valid),
    .RX_KIND(rx_kind), .RX_DEST(rx_dest), .RX_CHANNEL_MATCH(rx_chan), .RX_QUAD0(q0),
    .RX_QUAD1(q1), .GENERAL_RECEIVE_FIFO_FULL(fifo_full), .RX_STORE(store),
    .RX_ACK_BUSY(busy), .RX_FIRST_QUAD_ONLY(firstq), .RX_SELF_ID_MERGE(merge),
    .RX_STATUS(status), .TX_ASYNC_REQ(tx_a), .TX_ISO_REQ(tx_i), .TX_ASYNC_ARB(arb_a),
    .TX_ISO_ARB(arb_i), .LINK_CONTROL(ctrl));
  lcr_rx_model lcr_rx_model_inst (.clk(sys_clk), .go(go), .kind(kind), .dest(dest),
    .chan(chan), .good(good), .rx_valid(rx_valid), .rx_kind(rx_kind), .rx_dest(rx_dest),
    .rx_chan(rx_chan), .rx_quad0(q0), .rx_quad1(q1));
  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle; request held until ack is sampled high at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    dat_w <= d;
    @(posedge sys_clk);
    while (ack !== 1'b1)
      @(posedge sys_clk);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // one header, then {store, busy, first-only, merge, status} one cycle later
  task automatic rx(input logic [2:0] k, input logic [5:0] d, input logic c, input logic g,
    input logic [7:0] e);
    @(posedge sys_clk);
    go <= 1'b1;
    kind <= k;
    dest <= d;
    chan <= c;
    good <= g;
    @(posedge sys_clk);
    go <= 1'b0;
    @(negedge sys_clk);
    check({24'h0, store, busy, firstq, merge, status}, {24'h0, e});
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog well beyond the hundred-odd cycles the sequence needs
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    errors++;
    print_verdict();
  end
  // main sequence; transmit requests stay high so gating shows on every write
  initial
  begin
    {reset_n, cyc, stb, we, bus_reset, fifo_full, go, chan, good} = 9'h0;
    {adr, sel, dat_w, kind, dest} = {8'h0, 4'hf, 32'h0, 3'h0, 6'h0};
    node_id = 6'h05;
    tx_a = 1'b1;
    tx_i = 1'b1;
    lanes = 4'hf;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    bus(1'b0, lcr_pkg::LINK_CONTROL_ADDR, 32'h0);
    check(rd, lcr_pkg::LINK_CONTROL_RESET);
    check({30'h0, arb_a, arb_i}, 32'h0);
    bus(1'b1, 8'h08, 32'hffff_ffff);
    bus(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0000_01ff);
    check({23'h0, ctrl}, 32'h0000_01ff);
    // lane 0 alone leaves bit 8 as it was
    lanes = 4'h1;
    bus(1'b1, 8'h08, 32'h0);
    lanes = 4'hf;
    check({23'h0, ctrl}, 32'h0000_0100);
    bus(1'b1, 8'h0c, 32'hffff_ffff);
    bus(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h0);
    check({23'h0, ctrl}, 32'h0000_0100);
    // own address, other address, full fifo, broadcast
    bus(1'b1, 8'h08, 32'h041);
    rx(lcr_pkg::KIND_ASYNC, 6'h05, 1'b0, 1'b1, 8'h80);
    rx(lcr_pkg::KIND_ASYNC, 6'h09, 1'b0, 1'b1, 8'h00);
    @(posedge sys_clk);
    fifo_full <= 1'b1;
    rx(lcr_pkg::KIND_ASYNC, 6'h05, 1'b0, 1'b1, 8'h40);
    @(posedge sys_clk);
    fifo_full <= 1'b0;
    bus(1'b1, 8'h08, 32'h040);
    rx(lcr_pkg::KIND_ASYNC, 6'h05, 1'b0, 1'b1, 8'h00);
    rx(lcr_pkg::KIND_ASYNC, 6'h3f, 1'b0, 1'b1, 8'h80);
    bus(1'b1, 8'h08, 32'h045);
    rx(lcr_pkg::KIND_ASYNC, 6'h05, 1'b0, 1'b1, 8'h40);
    rx(lcr_pkg::KIND_ASYNC, 6'h3f, 1'b0, 1'b1, 8'h80);
    bus(1'b1, 8'h08, 32'h005);
    rx(lcr_pkg::KIND_ASYNC, 6'h3f, 1'b0, 1'b1, 8'h00);
    // isochronous and cycle start acceptance
    bus(1'b1, 8'h08, 32'h108);
    rx(lcr_pkg::KIND_ISO, 6'h3f, 1'b0, 1'b1, 8'h80);
    bus(1'b1, 8'h08, 32'h100);
    rx(lcr_pkg::KIND_ISO, 6'h3f, 1'b0, 1'b1, 8'h00);
    rx(lcr_pkg::KIND_ISO, 6'h3f, 1'b1, 1'b1, 8'h80);
    bus(1'b1, 8'h08, 32'h008);
    rx(lcr_pkg::KIND_ISO, 6'h3f, 1'b1, 1'b1, 8'h00);
    rx(lcr_pkg::KIND_CYCLE_START, 6'h3f, 1'b0, 1'b1, 8'h00);
    bus(1'b1, 8'h08, 32'h010);
    rx(lcr_pkg::KIND_CYCLE_START, 6'h3f, 1'b0, 1'b1, 8'h80);
    // self-id capture with good and corrupted pairs, then link-on and phy config
    bus(1'b1, 8'h08, 32'h002);
    rx(lcr_pkg::KIND_SELF_ID, 6'h3f, 1'b0, 1'b1, 8'h91);
    rx(lcr_pkg::KIND_SELF_ID, 6'h3f, 1'b0, 1'b0, 8'h9d);
    rx(lcr_pkg::KIND_LINK_ON, 6'h3f, 1'b0, 1'b1, 8'ha0);
    rx(lcr_pkg::KIND_PHY_CONFIG, 6'h3f, 1'b0, 1'b1, 8'ha0);
    bus(1'b1, 8'h08, 32'h0a0);
    rx(lcr_pkg::KIND_SELF_ID, 6'h3f, 1'b0, 1'b1, 8'h00);
    check({30'h0, arb_a, arb_i}, 32'h3);
    bus(1'b1, 8'h08, 32'h020);
    check({30'h0, arb_a, arb_i}, 32'h2);
    // bus reset drops only the async enables; software then sets them again
    bus(1'b1, 8'h08, 32'h1ff);
    bus_reset <= 1'b1;
    @(posedge sys_clk);
    bus_reset <= 1'b0;
    bus(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0000_019f);
    check({30'h0, arb_a, arb_i}, 32'h1);
    bus(1'b1, 8'h08, 32'h1ff);
    bus(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0000_01ff);
    // bus reset in the same cycle as a write still clears both async enables
    bus_reset <= 1'b1;
    bus(1'b1, 8'h08, 32'h1ff);
    bus_reset <= 1'b0;
    check({23'h0, ctrl}, 32'h0000_019f);
    // no request, no arbitration, even with the iso enable set
    tx_a <= 1'b0;
    tx_i <= 1'b0;
    @(posedge sys_clk);
    check({30'h0, arb_a, arb_i}, 32'h0);
    print_verdict();
  end
endmodule
